/* inc/kbm_pkg.sv */
// Constants for the keyboard/pointer host mailbox.
// Assumes an ISA host on the port pins and an 8-bit core on the core ports.
//
// Overview of operation
// - Host write to 0x60 loads input data, clears command flag, sets input full.
// - Host write to 0x64 loads input data, sets command flag, sets input full.
// - Host data read returns output data; with flags on clears output full, irq.
// - Three 8-bit registers: status, data/command write, data read.
// - Core output write loads host read data and sets status bit 0.
// - Every host write copies address bit 2 into status bit 3.
// - Flags on: key irq follows output full when port bit 24 set, else low.
// - Flags off: key irq follows port bit 24 directly.
// - Key irq output is zero after reset.
// - Flags on and port bit 25 set: pointer irq is inverse input full.
// - Flags off: pointer irq follows port bit 25 directly.
// - Port bit 21 is brought out as the address-line-20 gate.
// - Key clock/data open-drain, driven by inverse bits 26/27, read back.
// - Pointer clock/data open-drain, driven by inverse bits 23/22, read back.
// - Halt stops the ALU clock; host write or reset ends it.
// - Host-write wake calls interrupt if enabled, else next instruction.
// - Stop halts the oscillator; same wake sources; reset held for restart.
// - Exactly two core interrupts: input full and timer overflow.
// - Core has 2K program store and 256 bytes data RAM.
// - Core read of input data clears input full and its interrupt.
// - Status resets to zero; host reads it, core writes user bits.

package kbm_pkg;

  // ==========================================================
  // Host port map
  localparam logic [15:0] KBM_ADDR_DATA   = 16'h0060;
  localparam logic [15:0] KBM_ADDR_CMD    = 16'h0064;
  localparam int          KBM_ADDR_SEL    = 2;

  // ==========================================================
  // Status register fields
  localparam int          KBM_ST_OBF      = 0;
  localparam int          KBM_ST_IBF      = 1;
  localparam int          KBM_ST_CMD      = 3;
  localparam logic [7:0]  KBM_ST_USER_MSK = 8'hF4;
  localparam logic [7:0]  KBM_ST_RESET    = 8'h00;

  // ==========================================================
  // Core port 2 bit positions (bit n means port pin 2n)
  localparam int          KBM_P_A20       = 1;
  localparam int          KBM_P_PDAT      = 2;
  localparam int          KBM_P_PCLK      = 3;
  localparam int          KBM_P_HOST_KEY_IRQ      = 4;
  localparam int          KBM_P_PIRQ      = 5;
  localparam int          KBM_P_KEY_CLOCK_PIN      = 6;
  localparam int          KBM_P_KEY_DATA_PIN      = 7;

  // ==========================================================
  // Memory sizes
  localparam int          KBM_ROM_DEPTH   = 2048;
  localparam int          KBM_RAM_DEPTH   = 256;

  // ==========================================================
  // Reset length the system must give
  localparam int          KBM_RST_PERIODS = 24;
  localparam int          KBM_RST_REF_MHZ = 16;

  // Power states
  typedef enum logic [1:0] {KBM_PWR_RUN, KBM_PWR_SOFT, KBM_PWR_HARD}
    kbm_pwr_t;

endpackage

/* design/kbm_sync.sv */
// Three-stage synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/1ps

module kbm_sync
#(
  parameter int W = 1
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  input  wire logic [W-1:0] i_init,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic         init_done_reg;

  // ==========================================================
  // Synchroniser chain
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= init_done_reg ? i_async : i_init;
      s2_reg <= init_done_reg ? s1_reg : i_init;
      s3_reg <= init_done_reg ? s2_reg : i_init;
    end
  end

  // Marks the first cycle after release
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      init_done_reg <= 1'b0;
    end
    else if (!init_done_reg)
    begin
      init_done_reg <= 1'b1;
    end
  end

  // Per-bit agreement filter
  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          o_sync[b] <= 1'b0;
        else if (!init_done_reg)
          o_sync[b] <= i_init[b];
        else if (s2_reg[b] == s3_reg[b])
          o_sync[b] <= s3_reg[b];
      end
    end
  endgenerate

endmodule

/* design/kbm_buf2.sv */
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides on the same clock.
`timescale 1ns/1ps

module kbm_buf2
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_in_valid,
  output logic            o_in_ready,
  input  wire logic [7:0] i_in_data,
  output logic            o_out_valid,
  input  wire logic       i_out_ready,
  output logic      [7:0] o_out_data
);

  logic [7:0] mem_reg [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] cnt_reg;
  logic       push;
  logic       pop;

  assign o_in_ready  = (cnt_reg != 2'd2);
  assign o_out_valid = (cnt_reg != 2'd0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // ==========================================================
  // Storage and pointers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        mem_reg[wr_ptr_reg] <= i_in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        cnt_reg <= cnt_reg + 2'd1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 2'd1;
    end
  end

endmodule

/* design/kbm_mailbox.sv */
// Host mailbox of the keyboard controller: host ports, status,
// interrupt pins, open-drain serial pins, power-down and core memories.
// Assumes ISA strobes asynchronous to i_clk and a core on i_clk.
`timescale 1ns/1ps

module kbm_mailbox
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // ISA host side
  input  wire logic [15:0] i_sa,
  input  wire logic        i_iow_n,
  input  wire logic        i_ior_n,
  input  wire logic [7:0]  i_sd,
  output logic      [7:0]  o_sd,
  output logic             o_sd_oe,
  output logic             o_host_key_irq,
  output logic             o_host_pointer_irq,
  output logic             o_addr20_gate,
  // Serial pins, open drain
  input  wire logic        i_key_clock_pin,
  output logic             o_key_clock_pin,
  output logic             o_key_clock_pin_oe,
  input  wire logic        i_key_data_pin,
  output logic             o_key_data_pin,
  output logic             o_key_data_pin_oe,
  input  wire logic        i_pointer_clock_pin,
  output logic             o_pointer_clock_pin,
  output logic             o_pointer_clock_pin_oe,
  input  wire logic        i_pointer_data_pin,
  output logic             o_pointer_data_pin,
  output logic             o_pointer_data_pin_oe,
  // Core side
  input  wire logic [7:0]  i_core_port2,
  input  wire logic        i_core_en_flags,
  input  wire logic        i_core_obuf_valid,
  output logic             o_core_obuf_ready,
  input  wire logic [7:0]  i_core_obuf_data,
  input  wire logic        i_core_ibuf_rd,
  output logic      [7:0]  o_core_input_buffer,
  input  wire logic        i_core_status_wr,
  input  wire logic [7:0]  i_core_status_data,
  output logic      [7:0]  o_core_status,
  output logic             o_test_in_key_clk,
  output logic             o_test_in_ptr_clk,
  output logic             o_port_in_key_dat,
  output logic             o_port_in_ptr_dat,
  input  wire logic        i_core_ibf_int_en,
  input  wire logic        i_core_timer_ovf,
  output logic             o_core_irq_ibf,
  output logic             o_core_irq_timer,
  input  wire logic        i_core_halt,
  input  wire logic        i_core_stop,
  output logic             o_core_alu_clk_en,
  output logic             o_core_osc_en,
  output logic             o_core_wake_call,
  output logic             o_core_wake_next,
  // Core memories
  input  wire logic        i_rom_wr,
  input  wire logic [10:0] i_rom_addr,
  input  wire logic [7:0]  i_rom_wdata,
  output logic      [7:0]  o_rom_rdata,
  input  wire logic        i_ram_wr,
  input  wire logic [7:0]  i_ram_addr,
  input  wire logic [7:0]  i_ram_wdata,
  output logic      [7:0]  o_ram_rdata
);

  localparam int SW = 16 + 8 + 2 + 4;

  // ==========================================================
  // Pin synchronisation
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_init;
  logic [SW-1:0] sync_out;
  logic [15:0]   sa_s;
  logic [7:0]    sd_s;
  logic          iow_n_s;
  logic          ior_n_s;
  logic [3:0]    pins_s;

  assign sync_in   = {i_sa, i_sd, i_iow_n, i_ior_n, i_key_clock_pin,
                      i_key_data_pin, i_pointer_clock_pin,
                      i_pointer_data_pin};
  assign sync_init = {{24{1'b0}}, 2'b11, 4'b1111};
  assign {sa_s, sd_s, iow_n_s, ior_n_s, pins_s} = sync_out;

  kbm_sync #(.W(SW)) u_sync
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (sync_in),
    .i_init  (sync_init),
    .o_sync  (sync_out)
  );

  // ==========================================================
  // Strobe edge detection on filtered strobes
  logic iow_n_d_reg;
  logic ior_n_d_reg;
  logic wr_start;
  logic rd_start;
  logic rd_end;
  logic hit_data;
  logic hit_cmd;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      iow_n_d_reg <= 1'b1;
      ior_n_d_reg <= 1'b1;
    end
    else
    begin
      iow_n_d_reg <= iow_n_s;
      ior_n_d_reg <= ior_n_s;
    end
  end

  assign wr_start = iow_n_d_reg && !iow_n_s;
  assign rd_start = ior_n_d_reg && !ior_n_s;
  assign rd_end   = !ior_n_d_reg && ior_n_s;
  assign hit_data = (sa_s == kbm_pkg::KBM_ADDR_DATA);
  assign hit_cmd  = (sa_s == kbm_pkg::KBM_ADDR_CMD);

  logic host_wr;
  assign host_wr = wr_start && (hit_data || hit_cmd);

  // ==========================================================
  // Output buffer path
  logic       ob_valid;
  logic       ob_ready;
  logic [7:0] ob_data;
  logic       obf_reg;
  logic       ibf_reg;
  logic       ob_load;

  kbm_buf2 u_obuf
  (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_core_obuf_valid),
    .o_in_ready  (o_core_obuf_ready),
    .i_in_data   (i_core_obuf_data),
    .o_out_valid (ob_valid),
    .i_out_ready (ob_ready),
    .o_out_data  (ob_data)
  );

  // Only refill once the host has taken the last byte
  assign ob_ready = !obf_reg;
  assign ob_load  = ob_valid && ob_ready;

  // ==========================================================
  // Host data registers
  logic [7:0] in_data_reg;
  logic [7:0] out_data_reg;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      in_data_reg <= 8'h00;
    else if (host_wr)
      in_data_reg <= sd_s;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      out_data_reg <= 8'h00;
    else if (ob_load)
      out_data_reg <= ob_data;
  end

  assign o_core_input_buffer = in_data_reg;

  // ==========================================================
  // Status flags; a set in the same cycle as a clear wins
  logic       rd_data_reg;
  logic       cmd_reg;
  logic [7:0] user_reg;
  logic       obf_clr;

  // Flag-driven clear at end of host data read
  assign obf_clr = rd_end && rd_data_reg && i_core_en_flags;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rd_data_reg <= 1'b0;
    else if (rd_start)
      rd_data_reg <= hit_data;
    else if (rd_end)
      rd_data_reg <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      obf_reg <= kbm_pkg::KBM_ST_RESET[kbm_pkg::KBM_ST_OBF];
    else if (ob_load)
      obf_reg <= 1'b1;
    else if (obf_clr)
      obf_reg <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ibf_reg <= kbm_pkg::KBM_ST_RESET[kbm_pkg::KBM_ST_IBF];
    else if (host_wr)
      ibf_reg <= 1'b1;
    else if (i_core_ibuf_rd)
      ibf_reg <= 1'b0;
  end

  // Command flag copies address bit 2 on every host write
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cmd_reg <= kbm_pkg::KBM_ST_RESET[kbm_pkg::KBM_ST_CMD];
    else if (host_wr)
      cmd_reg <= sa_s[kbm_pkg::KBM_ADDR_SEL];
  end

  // User bits are written by the core only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      user_reg <= kbm_pkg::KBM_ST_RESET;
    else if (i_core_status_wr)
      user_reg <= i_core_status_data & kbm_pkg::KBM_ST_USER_MSK;
  end

  logic [7:0] status;
  always_comb
  begin
    status                        = user_reg;
    status[kbm_pkg::KBM_ST_CMD]   = cmd_reg;
    status[kbm_pkg::KBM_ST_IBF]   = ibf_reg;
    status[kbm_pkg::KBM_ST_OBF]   = obf_reg;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_core_status <= kbm_pkg::KBM_ST_RESET;
    else
      o_core_status <= status;
  end

  // ==========================================================
  // Host read data and bus drive
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_sd    <= 8'h00;
      o_sd_oe <= 1'b0;
    end
    else if (rd_start && hit_data)
    begin
      o_sd    <= out_data_reg;
      o_sd_oe <= 1'b1;
    end
    else if (rd_start && hit_cmd)
    begin
      o_sd    <= status;
      o_sd_oe <= 1'b1;
    end
    else if (ior_n_s)
      o_sd_oe <= 1'b0;
  end

  // ==========================================================
  // Host interrupt pins and gate output
  logic [7:0] p2;
  assign p2 = i_core_port2;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_host_key_irq     <= 1'b0;
      o_host_pointer_irq <= 1'b0;
      o_addr20_gate      <= 1'b0;
    end
    else
    begin
      if (i_core_en_flags)
        o_host_key_irq <= p2[kbm_pkg::KBM_P_HOST_KEY_IRQ] && obf_reg;
      else
        o_host_key_irq <= p2[kbm_pkg::KBM_P_HOST_KEY_IRQ];
      if (i_core_en_flags)
        o_host_pointer_irq <= p2[kbm_pkg::KBM_P_PIRQ] && !ibf_reg;
      else
        o_host_pointer_irq <= p2[kbm_pkg::KBM_P_PIRQ];
      o_addr20_gate <= p2[kbm_pkg::KBM_P_A20];
    end
  end

  // ==========================================================
  // Open-drain serial pins: a set port bit pulls the pin low
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_key_clock_pin_oe     <= 1'b0;
      o_key_data_pin_oe      <= 1'b0;
      o_pointer_clock_pin_oe <= 1'b0;
      o_pointer_data_pin_oe  <= 1'b0;
    end
    else
    begin
      o_key_clock_pin_oe     <= p2[kbm_pkg::KBM_P_KEY_CLOCK_PIN];
      o_key_data_pin_oe      <= p2[kbm_pkg::KBM_P_KEY_DATA_PIN];
      o_pointer_clock_pin_oe <= p2[kbm_pkg::KBM_P_PCLK];
      o_pointer_data_pin_oe  <= p2[kbm_pkg::KBM_P_PDAT];
    end
  end

  // Driven level is always low
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_key_clock_pin     <= 1'b0;
      o_key_data_pin      <= 1'b0;
      o_pointer_clock_pin <= 1'b0;
      o_pointer_data_pin  <= 1'b0;
    end
  end

  // Pin levels read back to the core test and port inputs
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_test_in_key_clk <= 1'b1;
      o_port_in_key_dat <= 1'b1;
      o_test_in_ptr_clk <= 1'b1;
      o_port_in_ptr_dat <= 1'b1;
    end
    else
    begin
      o_test_in_key_clk <= pins_s[3];
      o_port_in_key_dat <= pins_s[2];
      o_test_in_ptr_clk <= pins_s[1];
      o_port_in_ptr_dat <= pins_s[0];
    end
  end

  // ==========================================================
  // Core interrupt requests
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_core_irq_ibf   <= 1'b0;
      o_core_irq_timer <= 1'b0;
    end
    else
    begin
      o_core_irq_ibf   <= (ibf_reg || host_wr) && !i_core_ibuf_rd
                          && i_core_ibf_int_en;
      o_core_irq_timer <= i_core_timer_ovf;
    end
  end

  // ==========================================================
  // Power-down state machine
  kbm_pkg::kbm_pwr_t pwr_reg;
  kbm_pkg::kbm_pwr_t pwr_next;

  always_comb
  begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      kbm_pkg::KBM_PWR_RUN:
        if (i_core_stop)
          pwr_next = kbm_pkg::KBM_PWR_HARD;
        else if (i_core_halt)
          pwr_next = kbm_pkg::KBM_PWR_SOFT;
      kbm_pkg::KBM_PWR_SOFT,
      kbm_pkg::KBM_PWR_HARD:
        if (host_wr)
          pwr_next = kbm_pkg::KBM_PWR_RUN;
      default:
        pwr_next = kbm_pkg::KBM_PWR_RUN;
    endcase
  end

  // Power state register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pwr_reg <= kbm_pkg::KBM_PWR_RUN;
    else
      pwr_reg <= pwr_next;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_core_alu_clk_en <= 1'b1;
      o_core_osc_en     <= 1'b1;
      o_core_wake_call  <= 1'b0;
      o_core_wake_next  <= 1'b0;
    end
    else
    begin
      o_core_alu_clk_en <= (pwr_next == kbm_pkg::KBM_PWR_RUN);
      o_core_osc_en     <= (pwr_next != kbm_pkg::KBM_PWR_HARD);
      o_core_wake_call  <= (pwr_reg != kbm_pkg::KBM_PWR_RUN) && host_wr
                           && i_core_ibf_int_en;
      o_core_wake_next  <= (pwr_reg != kbm_pkg::KBM_PWR_RUN) && host_wr
                           && !i_core_ibf_int_en;
    end
  end

  // ==========================================================
  // Program store and data RAM of the core
  logic [7:0] rom_mem [kbm_pkg::KBM_ROM_DEPTH];
  logic [7:0] ram_mem [kbm_pkg::KBM_RAM_DEPTH];

  always_ff @(posedge i_clk)
  begin
    if (i_rom_wr)
      rom_mem[i_rom_addr] <= i_rom_wdata;
    o_rom_rdata <= rom_mem[i_rom_addr];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ram_wr)
      ram_mem[i_ram_addr] <= i_ram_wdata;
    o_ram_rdata <= ram_mem[i_ram_addr];
  end

endmodule

/* test/kbm_mailbox_props.sv */
// Port checker for the host mailbox.
// Assumes a bind onto kbm_mailbox, all logic on i_clk.
`timescale 1ns/1ps

module kbm_mailbox_props
(
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_iow_n,
  input wire logic [7:0] i_core_port2,
  input wire logic       i_core_en_flags,
  input wire logic       i_core_ibuf_rd,
  input wire logic       i_core_timer_ovf,
  input wire logic       i_core_halt,
  input wire logic       i_core_stop,
  input wire logic       o_host_key_irq,
  input wire logic       o_host_pointer_irq,
  input wire logic       o_addr20_gate,
  input wire logic       o_key_clock_pin_oe,
  input wire logic       o_key_data_pin_oe,
  input wire logic       o_pointer_clock_pin_oe,
  input wire logic       o_pointer_data_pin_oe,
  input wire logic [7:0] o_core_status,
  input wire logic       o_core_irq_ibf,
  input wire logic       o_core_irq_timer,
  input wire logic       o_core_alu_clk_en,
  input wire logic       o_core_osc_en
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_reset_clear: assert property (
    $rose(i_rst_n) |-> o_core_status == 8'h00 && !o_host_key_irq)
    else $error("reset state wrong");
  chk_key_forced_low: assert property (
    i_core_en_flags && !i_core_port2[4] |=> !o_host_key_irq)
    else $error("key irq not held low");
  chk_key_direct: assert property (
    !i_core_en_flags |=> o_host_key_irq == $past(i_core_port2[4]))
    else $error("key irq wrong");
  chk_ptr_direct: assert property (
    !i_core_en_flags |=> o_host_pointer_irq == $past(i_core_port2[5]))
    else $error("pointer irq wrong");
  chk_gate_copy: assert property (
    1'b1 |=> o_addr20_gate == $past(i_core_port2[1]))
    else $error("gate wrong");
  chk_key_pin_drive: assert property (
    1'b1 |=> o_key_clock_pin_oe == $past(i_core_port2[6])
      && o_key_data_pin_oe == $past(i_core_port2[7]))
    else $error("key pin drive wrong");
  chk_ptr_pin_drive: assert property (
    1'b1 |=> o_pointer_clock_pin_oe == $past(i_core_port2[3])
      && o_pointer_data_pin_oe == $past(i_core_port2[2]))
    else $error("pointer pin drive wrong");
  chk_ibf_clear: assert property (
    i_core_ibuf_rd && i_iow_n |-> ##[1:2] !o_core_irq_ibf)
    else $error("ibf irq not withdrawn");
  chk_timer_echo: assert property (
    1'b1 |=> o_core_irq_timer == $past(i_core_timer_ovf))
    else $error("timer irq wrong");
  chk_halt_soft: assert property (
    i_core_halt |=> !o_core_alu_clk_en && o_core_osc_en)
    else $error("halt wrong");
  chk_stop_hard: assert property (
    i_core_stop |=> !o_core_osc_en && !o_core_alu_clk_en)
    else $error("stop wrong");
endmodule

bind kbm_mailbox kbm_mailbox_props u_props (.*);

/* test/kbm_host_model.sv */
// Host processor model driving the port strobes.
// Assumes strobes held eight cycles low and eight high.
`timescale 1ns/1ps

module kbm_host_model
(
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_sd,
  output logic      [15:0] o_sa,
  output logic             o_iow_n,
  output logic             o_ior_n,
  output logic      [7:0]  o_sd
);
  // Idle bus at time zero
  initial
  begin
    {o_sa, o_iow_n, o_ior_n, o_sd} = {16'hFFFF, 2'b11, 8'hFF};
  end

  // Port write; caller waits for input full clear first
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_sa <= a;
    o_sd <= d;
    o_iow_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    o_iow_n <= 1'b1;
    @(posedge i_clk);
    o_sa <= ~a;
    o_sd <= ~d;
    repeat (7) @(posedge i_clk);
  endtask

  // Port read; data taken at the last low cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_sa <= a;
    o_ior_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    d = i_sd;
    o_ior_n <= 1'b1;
    @(posedge i_clk);
    o_sa <= ~a;
    repeat (7) @(posedge i_clk);
  endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the host mailbox.
// Assumes the host model on the port side, bench as core.
`timescale 1ns/1ps

module testbench;
  logic        clk, rst_n, iow_n, ior_n, host_key_irq, pirq, a20, ordy, ov;
  logic        koc, kod, poc, pod, enf, ird, sw, ien, tov, iqb, iqt;
  logic        hlt, stp, aluen, oscen, wcall, wnext, romwr, ramwr;
  logic [15:0] sa;
  logic [10:0] romad;
  logic [7:0]  hsd, sd, p2, od, ib, swd, st, romwd, romrd;
  logic [7:0]  ramad, ramwd, ramrd, d;
  logic [3:0]  ext, rb;
  int          failures, tests_run, cyc, n_call, n_next;

  kbm_host_model u_host (.i_clk(clk), .i_sd(sd), .o_sa(sa),
    .o_iow_n(iow_n), .o_ior_n(ior_n), .o_sd(hsd));

  kbm_mailbox u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_sa(sa),
    .i_iow_n(iow_n), .i_ior_n(ior_n), .i_sd(hsd), .o_sd(sd),
    .o_sd_oe(), .o_host_key_irq(host_key_irq), .o_host_pointer_irq(pirq),
    .o_addr20_gate(a20), .i_key_clock_pin(ext[3] & ~koc),
    .o_key_clock_pin(), .o_key_clock_pin_oe(koc),
    .i_key_data_pin(ext[2] & ~kod), .o_key_data_pin(),
    .o_key_data_pin_oe(kod), .i_pointer_clock_pin(ext[1] & ~poc),
    .o_pointer_clock_pin(), .o_pointer_clock_pin_oe(poc),
    .i_pointer_data_pin(ext[0] & ~pod), .o_pointer_data_pin(),
    .o_pointer_data_pin_oe(pod), .i_core_port2(p2),
    .i_core_en_flags(enf), .i_core_obuf_valid(ov),
    .o_core_obuf_ready(ordy), .i_core_obuf_data(od),
    .i_core_ibuf_rd(ird), .o_core_input_buffer(ib),
    .i_core_status_wr(sw), .i_core_status_data(swd),
    .o_core_status(st), .o_test_in_key_clk(rb[3]),
    .o_port_in_key_dat(rb[2]), .o_test_in_ptr_clk(rb[1]),
    .o_port_in_ptr_dat(rb[0]), .i_core_ibf_int_en(ien),
    .i_core_timer_ovf(tov), .o_core_irq_ibf(iqb),
    .o_core_irq_timer(iqt), .i_core_halt(hlt), .i_core_stop(stp),
    .o_core_alu_clk_en(aluen), .o_core_osc_en(oscen),
    .o_core_wake_call(wcall), .o_core_wake_next(wnext),
    .i_rom_wr(romwr), .i_rom_addr(romad), .i_rom_wdata(romwd),
    .o_rom_rdata(romrd), .i_ram_wr(ramwr), .i_ram_addr(ramad),
    .i_ram_wdata(ramwd), .o_ram_rdata(ramrd));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Wake pulse counters and hang guard
  always @(posedge clk)
  begin
    n_call += wcall;
    n_next += wnext;
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Core reads the input byte
  task automatic pop();
    @(posedge clk) ird <= 1'b1;
    @(posedge clk) ird <= 1'b0;
    tick(4);
  endtask

  task automatic t_write();
    @(posedge clk) {enf, ien, p2} <= {2'b11, 8'h20};
    for (int i = 0; i < 2; i++)
    begin
      u_host.wr(i ? 16'h0064 : 16'h0060, 8'h30 + i);
      cmp("input byte", 8'h30 + i, ib);
      cmp("cmd and ibf", i ? 8'h0A : 8'h02, st & 8'h0B);
      cmp("pointer irq", 8'h00, pirq);
      cmp("ibf irq", 8'h01, iqb);
      pop();
      cmp("ibf clear", 8'h00, st[1]);
      cmp("pointer irq", 8'h01, pirq);
    end
  endtask

  task automatic t_status();
    @(posedge clk) {sw, swd} <= {1'b1, 8'hFF};
    @(posedge clk) sw <= 1'b0;
    tick(3);
    cmp("status", 8'hFC, st);
    u_host.rd(16'h0064, d);
    cmp("host status", 8'hFC, d);
  endtask

  task automatic t_stream();
    @(posedge clk) {ov, p2} <= {1'b1, 8'h30};
    for (int i = 0; i < 3; i++)
    begin
      od <= 8'hA0 + i;
      do @(negedge clk); while (ordy !== 1'b1);
      @(posedge clk);
    end
    ov <= 1'b0;
    tick(4);
    cmp("ready full", 8'h00, ordy);
    cmp("obf", 8'h01, st[0]);
    cmp("key irq", 8'h01, host_key_irq);
    for (int i = 0; i < 3; i++)
    begin
      u_host.rd(16'h0060, d);
      cmp("read byte", 8'hA0 + i, d);
    end
    cmp("obf", 8'h00, st[0]);
    cmp("key irq", 8'h00, host_key_irq);
  endtask

  task automatic t_direct();
    @(posedge clk) enf <= 1'b0;
    for (int v = 0; v < 4; v++)
    begin
      @(posedge clk) p2 <= 8'(v << 4);
      tick(3);
      cmp("irq pins", 8'(v), {pirq, host_key_irq});
    end
  endtask

  task automatic t_pins();
    @(posedge clk) {p2, ext} <= {8'h00, 4'hA};
    tick(8);
    cmp("readback", 8'h0A, rb);
    @(posedge clk) {p2, ext} <= {8'hCC, 4'hF};
    tick(8);
    cmp("readback", 8'h00, rb);
    @(posedge clk) p2 <= 8'h00;
  endtask

  task automatic t_power();
    @(posedge clk) {ien, hlt} <= 2'b11;
    @(posedge clk) hlt <= 1'b0;
    tick(2);
    cmp("soft clocks", 8'h01, {aluen, oscen});
    u_host.wr(16'h0060, 8'h55);
    cmp("woken", 8'h03, {aluen, oscen});
    cmp("wake call", 8'h01, n_call);
    pop();
    @(posedge clk) {ien, stp} <= 2'b01;
    @(posedge clk) stp <= 1'b0;
    tick(2);
    cmp("hard clocks", 8'h00, {aluen, oscen});
    u_host.wr(16'h0060, 8'h66);
    cmp("woken", 8'h03, {aluen, oscen});
    cmp("wake next", 8'h01, n_next);
    pop();
    @(posedge clk) tov <= 1'b1;
    @(posedge clk) tov <= 1'b0;
    @(negedge clk);
    cmp("timer irq", 8'h01, iqt);
  endtask

  task automatic t_mem();
    @(posedge clk) {romwr, romad, romwd} <= {1'b1, 11'h7FF, 8'hA5};
    {ramwr, ramad, ramwd} <= {1'b1, 8'hFF, 8'h5A};
    @(posedge clk) {romwr, ramwr} <= 2'b00;
    tick(2);
    cmp("rom", 8'hA5, romrd);
    cmp("ram", 8'h5A, ramrd);
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {rst_n, ov, enf, ird, sw, ien, tov, hlt, stp, romwr, ramwr} = '0;
    {p2, od, swd, romwd, ramad, ramwd, romad} = '0;
    ext = 4'hF;
    repeat (64) @(posedge clk);
    rst_n <= 1'b1;
    tick(6);
    cmp("reset status", 8'h00, st);
    cmp("reset key irq", 8'h00, host_key_irq);
    t_write();
    t_status();
    t_stream();
    t_direct();
    t_pins();
    t_power();
    t_mem();
    tally_and_finish();
  end
endmodule
